// [hdl/disp_out_pkg.sv]
// Constants, register map and carrier types of the display output stage.
// Assumes a single 100 MHz system clock shared by every user of it.
package disp_out_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWR_STEP_US   = 10;
  localparam int PWR_STEP_CYC  = (PWR_STEP_US * 1000) / CLK_PERIOD_NS;
  localparam int PWR_TMR_W     = 12;

  // Structure
  localparam int FIFO_DEPTH = 32;
  localparam int DLY_TAPS   = 8;
  localparam int DLY_SEL_W  = 3;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CFG_VIDEO = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CFG_PANEL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SYNC_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h0C;

  // Field positions
  localparam int VID_RUN_BIT       = 0;
  localparam int VID_FMT565_BIT    = 29;
  localparam int PNL_POWER_BIT     = 6;
  localparam int PNL_DATA_EN_BIT   = 7;
  localparam int PNL_EVEN_EN_BIT   = 12;
  localparam int PNL_ID_DIR_BIT    = 24;
  localparam int PNL_ID_LINE_BIT   = 25;
  localparam int PNL_ID_CLK_BIT    = 26;
  localparam int SYN_LINE_DLY_LSB  = 0;
  localparam int SYN_FRAME_DLY_LSB = 4;
  localparam int SYN_LINE_POL_BIT  = 8;
  localparam int SYN_FRAME_POL_BIT = 9;
  localparam int ST_OVERFLOW_BIT   = 0;
  localparam int ST_ID_LINE_BIT    = 1;
  localparam int ST_ISA_BIT        = 2;
  localparam int ST_SUPPLY_BIT     = 4;
  localparam int ST_DATA_BIT       = 5;
  localparam int ST_BKL_BIT        = 6;
  localparam int ST_LEVEL_LSB      = 8;

  // Writable bits and reset values
  localparam logic [DATA_W-1:0] VID_MASK  = 32'h2000_0001;
  localparam logic [DATA_W-1:0] PNL_MASK  = 32'h0700_10C0;
  localparam logic [DATA_W-1:0] SYN_MASK  = 32'h0000_0377;
  localparam logic [DATA_W-1:0] VID_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    PWR_OFF, PWR_UP_SUPPLY, PWR_UP_DATA, PWR_ON, PWR_DN_BKL, PWR_DN_DATA
  } pwr_state_type;

  typedef struct packed {
    logic        pclk;
    logic        isa;
    logic        id_line;
    logic        active;
    logic        line;
    logic        frame;
    logic        pline;
    logic        pframe;
    logic [7:0]  overlay;
    logic [23:0] pixel;
  } link_in_type;

  typedef struct packed {
    logic        active;
    logic        line;
    logic        frame;
    logic        pline;
    logic        pframe;
    logic [7:0]  overlay;
    logic [23:0] pixel;
  } pix_word_type;

  localparam int PIX_WORD_W = $bits(pix_word_type);

  // Pixel word to 6:6:6 panel lanes; 5-bit fields widen by MSB copy
  function automatic logic [17:0] panel_map(input logic [23:0] px,
                                            input logic        fmt565);
    if (fmt565)
      return {px[15:11], px[15], px[10:5], px[4:0], px[4]};
    return {px[23:18], px[15:10], px[7:2]};
  endfunction : panel_map

endpackage : disp_out_pkg

// [hdl/disp_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
module disp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  // Fill side
  input  wire logic                     i_in_valid,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output logic                          o_in_ready,
  // Drain side
  output logic                          o_out_valid,
  output logic [WIDTH-1:0]              o_out_data,
  input  wire logic                     i_out_ready,
  // Fill level
  output logic [$clog2(DEPTH):0]        o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push_w = i_in_valid & o_in_ready;
  wire              pop_w  = o_out_valid & i_out_ready;

  assign o_level     = wr_q - rd_q;
  assign o_in_ready  = o_level != (AW+1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (push_w)
      mem[wr_q[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (AW+1)'(push_w);
      rd_q <= rd_q + (AW+1)'(pop_w);
    end
  end

endmodule : disp_fifo

// [hdl/disp_pwr_seq.sv]
// Panel power sequencer: supply, then data, then backlight, and back.
// Assumes a synchronous request level and a kill level on the same clock.
module disp_pwr_seq
  import disp_out_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Control
  input  wire logic i_req,
  input  wire logic i_kill,
  // Panel power state
  output logic      o_supply,
  output logic      o_backlight,
  output logic      o_data_phase
);
  pwr_state_type        pwr_q;
  pwr_state_type        pwr_d;
  logic [PWR_TMR_W-1:0] tmr_q;
  wire                  tmr_done_w = tmr_q == '0;
  wire                  req_w      = i_req & ~i_kill;

  // A change of the request level starts the up or down walk
  always_comb
  begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_OFF:       if (req_w) pwr_d = PWR_UP_SUPPLY;
      PWR_UP_SUPPLY: if (tmr_done_w) pwr_d = PWR_UP_DATA;
      PWR_UP_DATA:   if (tmr_done_w) pwr_d = PWR_ON;
      PWR_ON:        if (!req_w) pwr_d = PWR_DN_BKL;
      PWR_DN_BKL:    if (tmr_done_w) pwr_d = PWR_DN_DATA;
      PWR_DN_DATA:   if (tmr_done_w) pwr_d = PWR_OFF;
      default:       pwr_d = PWR_OFF;
    endcase
    // Losing the panel pins mid-walk restarts the walk from off
    if (i_kill)
      pwr_d = PWR_OFF;
  end

  assign o_data_phase = (pwr_q == PWR_UP_DATA) || (pwr_q == PWR_ON) ||
                        (pwr_q == PWR_DN_BKL);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      pwr_q       <= PWR_OFF;
      tmr_q       <= '0;
      o_supply    <= 1'b0;
      o_backlight <= 1'b0;
    end
    else
    begin
      pwr_q       <= pwr_d;
      tmr_q       <= (pwr_d != pwr_q) ? PWR_TMR_W'(PWR_STEP_CYC) :
                     tmr_done_w ? tmr_q : tmr_q - 1'b1;
      o_supply    <= (pwr_d != PWR_OFF) & ~i_kill;
      o_backlight <= (pwr_d == PWR_ON) & ~i_kill;
    end
  end

  sequence bkl_held_off;
    !o_backlight [*8];
  endsequence

  chk_pwr_start: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    pwr_q == PWR_OFF && req_w |-> ##1 o_supply)
    else $error("supply did not start on power request");

  chk_bkl_after_supply: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_supply) |-> bkl_held_off)
    else $error("backlight came on too soon after supply");

endmodule : disp_pwr_seq

// [hdl/disp_out.sv]
// Display output stage: pixel port capture, sync pipelines, CRT and panel.
// Assumes the pixel port pins are asynchronous to I_CLK_SYS and that the
// pixel clock is well below half the system clock rate.
//
// The address-and-strobe port and the address map were left to the implementer.

module disp_out
  import disp_out_pkg::*;
(
  // System clock and reset
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST_B,
  // Register port
  input  wire logic [ADDR_W-1:0] I_REG_ADDR,
  input  wire logic [DATA_W-1:0] I_REG_WDATA,
  input  wire logic              I_REG_WR,
  input  wire logic              I_REG_RD,
  output logic [DATA_W-1:0]      O_REG_RDATA,
  // Pixel port from the display controller
  input  wire logic              I_GRAPHICS_DOT_CLOCK,
  input  wire logic [23:0]       I_PIXEL_DATA,
  input  wire logic [7:0]        I_VIDEO_OVERLAY_BUS,
  input  wire logic              I_DISPLAY_ACTIVE_QUALIFIER,
  input  wire logic              I_LINE_SYNC,
  input  wire logic              I_FRAME_SYNC,
  input  wire logic              I_PANEL_LINE_SYNC_IN,
  input  wire logic              I_PANEL_FRAME_SYNC_IN,
  // Pin mode strap
  input  wire logic              I_ISA_MASTER_MODE,
  // CRT syncs and video data
  output logic                   O_CRT_LINE_SYNC,
  output logic                   O_CRT_FRAME_SYNC,
  output logic [15:0]            O_VIDEO_DATA,
  // Flat panel
  output logic [17:0]            O_PANEL_DATA_BUS,
  output logic                   O_PANEL_CLOCK_OUT,
  output logic                   O_PANEL_EVEN_LATCH_CLOCK,
  output logic                   O_PANEL_LINE_SYNC_OUT,
  output logic                   O_PANEL_FRAME_SYNC_OUT,
  output logic                   O_PANEL_ACTIVE_OUT,
  output logic                   O_PANEL_PINS_OE,
  output logic                   O_PANEL_SUPPLY_ENABLE,
  output logic                   O_PANEL_BACKLIGHT_ENABLE,
  // Monitor identification channel
  output logic                   O_MONITOR_ID_SERIAL_CLOCK,
  input  wire logic              I_MONITOR_ID_SERIAL_LINE_I,
  output logic                   O_MONITOR_ID_SERIAL_LINE_O,
  output logic                   O_MONITOR_ID_SERIAL_LINE_OE
);
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    return addr == offset;
  endfunction : reg_hit

  link_in_type           link_raw;
  link_in_type           s1_q;
  link_in_type           s2_q;
  logic                  pclk_prev_q;
  logic [DATA_W-1:0]     cfg_vid_q;
  logic [DATA_W-1:0]     cfg_pnl_q;
  logic [DATA_W-1:0]     syn_ctrl_q;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     status_w;
  logic [DATA_W-1:0]     rd_mux_w;
  logic                  overflow_q;
  pix_word_type          pix_in_w;
  pix_word_type          cap_q;
  logic                  cap_vld_q;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [PIX_WORD_W-1:0] fifo_out_raw;
  pix_word_type          fifo_out;
  logic [LVL_W-1:0]      fifo_level;
  logic [DLY_TAPS-2:0]   line_pipe_q;
  logic [DLY_TAPS-2:0]   frame_pipe_q;
  logic [DLY_TAPS-1:0]   line_taps_w;
  logic [DLY_TAPS-1:0]   frame_taps_w;
  logic [DLY_SEL_W-1:0]  line_dly_w;
  logic [DLY_SEL_W-1:0]  frame_dly_w;
  logic                  even_tgl_q;
  logic                  supply_w;
  logic                  backlight_w;
  logic                  data_phase_w;

  // Pixel port pins cross in through two flops each
  assign link_raw = '{pclk:    I_GRAPHICS_DOT_CLOCK,
                      isa:     I_ISA_MASTER_MODE,
                      id_line: I_MONITOR_ID_SERIAL_LINE_I,
                      active:  I_DISPLAY_ACTIVE_QUALIFIER,
                      line:    I_LINE_SYNC,
                      frame:   I_FRAME_SYNC,
                      pline:   I_PANEL_LINE_SYNC_IN,
                      pframe:  I_PANEL_FRAME_SYNC_IN,
                      overlay: I_VIDEO_OVERLAY_BUS,
                      pixel:   I_PIXEL_DATA};

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      s1_q        <= '0;
      s2_q        <= '0;
      pclk_prev_q <= 1'b0;
    end
    else
    begin
      s1_q        <= link_raw;
      s2_q        <= s1_q;
      pclk_prev_q <= s2_q.pclk;
    end
  end

  wire edge_w = s2_q.pclk & ~pclk_prev_q;
  wire isa_w  = s2_q.isa;
  wire run_w  = cfg_vid_q[VID_RUN_BIT];
  wire fmt_w  = cfg_vid_q[VID_FMT565_BIT];

  // Register port decode
  wire wr_vid_w = I_REG_WR && reg_hit(I_REG_ADDR, REG_CFG_VIDEO);
  wire wr_pnl_w = I_REG_WR && reg_hit(I_REG_ADDR, REG_CFG_PANEL);
  wire wr_syn_w = I_REG_WR && reg_hit(I_REG_ADDR, REG_SYNC_CTRL);
  wire wr_st_w  = I_REG_WR && reg_hit(I_REG_ADDR, REG_STATUS);
  wire ovf_set_w = cap_vld_q & ~fifo_in_ready;
  wire ovf_clr_w = wr_st_w & I_REG_WDATA[ST_OVERFLOW_BIT];

  assign status_w = (DATA_W'(overflow_q)     << ST_OVERFLOW_BIT) |
                    (DATA_W'(s2_q.id_line)   << ST_ID_LINE_BIT)  |
                    (DATA_W'(isa_w)          << ST_ISA_BIT)      |
                    (DATA_W'(supply_w)       << ST_SUPPLY_BIT)   |
                    (DATA_W'(data_phase_w)   << ST_DATA_BIT)     |
                    (DATA_W'(backlight_w)    << ST_BKL_BIT)      |
                    (DATA_W'(fifo_level)     << ST_LEVEL_LSB);

  assign rd_mux_w =
    reg_hit(I_REG_ADDR, REG_CFG_VIDEO) ? cfg_vid_q  :
    reg_hit(I_REG_ADDR, REG_CFG_PANEL) ? cfg_pnl_q  :
    reg_hit(I_REG_ADDR, REG_SYNC_CTRL) ? syn_ctrl_q :
    reg_hit(I_REG_ADDR, REG_STATUS)    ? status_w   : '0;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      cfg_vid_q  <= VID_RESET;
      cfg_pnl_q  <= '0;
      syn_ctrl_q <= '0;
      overflow_q <= 1'b0;
      rdata_q    <= '0;
    end
    else
    begin
      if (wr_vid_w)
        cfg_vid_q <= I_REG_WDATA & VID_MASK;
      if (wr_pnl_w)
        cfg_pnl_q <= I_REG_WDATA & PNL_MASK;
      if (wr_syn_w)
        syn_ctrl_q <= I_REG_WDATA & SYN_MASK;
      overflow_q <= ovf_set_w | (overflow_q & ~ovf_clr_w);
      rdata_q    <= I_REG_RD ? rd_mux_w : '0;
    end
  end

  assign O_REG_RDATA = rdata_q;

  // Capture every pixel slot, blanking included, so syncs ride along
  assign pix_in_w = '{active:  s2_q.active,
                      line:    s2_q.line,
                      frame:   s2_q.frame,
                      pline:   s2_q.pline,
                      pframe:  s2_q.pframe,
                      overlay: s2_q.overlay,
                      pixel:   s2_q.pixel};

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      cap_q     <= '0;
      cap_vld_q <= 1'b0;
    end
    else
    begin
      if (edge_w)
        cap_q <= pix_in_w;
      cap_vld_q <= edge_w;
    end
  end

  // Output side drains one word per pixel clock while running
  wire pop_w = edge_w & run_w & fifo_out_valid;

  disp_fifo #(
    .WIDTH (PIX_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK_SYS),
    .i_rst_b     (I_RST_B),
    .i_in_valid  (cap_vld_q),
    .i_in_data   (cap_q),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_raw),
    .i_out_ready (pop_w),
    .o_level     (fifo_level)
  );

  assign fifo_out = pix_word_type'(fifo_out_raw);

  // CRT sync delay taps, tap 0 aligned with the pixel data
  assign line_dly_w  = syn_ctrl_q[SYN_LINE_DLY_LSB +: DLY_SEL_W];
  assign frame_dly_w = syn_ctrl_q[SYN_FRAME_DLY_LSB +: DLY_SEL_W];
  assign line_taps_w  = {line_pipe_q, fifo_out.line};
  assign frame_taps_w = {frame_pipe_q, fifo_out.frame};

  wire line_pol_w  = syn_ctrl_q[SYN_LINE_POL_BIT];
  wire frame_pol_w = syn_ctrl_q[SYN_FRAME_POL_BIT];

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      line_pipe_q      <= '0;
      frame_pipe_q     <= '0;
      O_CRT_LINE_SYNC  <= 1'b0;
      O_CRT_FRAME_SYNC <= 1'b0;
      O_VIDEO_DATA     <= '0;
    end
    else if (pop_w)
    begin
      line_pipe_q      <= line_taps_w[DLY_TAPS-2:0];
      frame_pipe_q     <= frame_taps_w[DLY_TAPS-2:0];
      O_CRT_LINE_SYNC  <= line_taps_w[line_dly_w] ^ line_pol_w;
      O_CRT_FRAME_SYNC <= frame_taps_w[frame_dly_w] ^ frame_pol_w;
      O_VIDEO_DATA     <= (fmt_w && fifo_out.active) ?
                          {fifo_out.pixel[23:16], fifo_out.overlay} :
                          '0;
    end
  end

  // Panel side
  disp_pwr_seq u_pwr_seq (
    .i_clk        (I_CLK_SYS),
    .i_rst_b      (I_RST_B),
    .i_req        (cfg_pnl_q[PNL_POWER_BIT]),
    .i_kill       (isa_w),
    .o_supply     (supply_w),
    .o_backlight  (backlight_w),
    .o_data_phase (data_phase_w)
  );

  wire pnl_live_w    = data_phase_w & ~isa_w;
  wire pnl_data_on_w = pnl_live_w & cfg_pnl_q[PNL_DATA_EN_BIT];
  wire even_on_w     = pnl_live_w & cfg_pnl_q[PNL_EVEN_EN_BIT];

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B || !pnl_data_on_w)
      O_PANEL_DATA_BUS <= '0;
    else if (pop_w)
      O_PANEL_DATA_BUS <= fifo_out.active ?
                          panel_map(fifo_out.pixel, fmt_w) : '0;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B || !pnl_live_w)
    begin
      O_PANEL_LINE_SYNC_OUT  <= 1'b0;
      O_PANEL_FRAME_SYNC_OUT <= 1'b0;
      O_PANEL_ACTIVE_OUT     <= 1'b0;
    end
    else if (pop_w)
    begin
      O_PANEL_LINE_SYNC_OUT  <= fifo_out.pline;
      O_PANEL_FRAME_SYNC_OUT <= fifo_out.pframe;
      O_PANEL_ACTIVE_OUT     <= fifo_out.active;
    end
  end

  // Panel clock rises mid-pixel, well after the data has settled
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_B)
    begin
      O_PANEL_CLOCK_OUT        <= 1'b0;
      O_PANEL_EVEN_LATCH_CLOCK <= 1'b0;
      even_tgl_q               <= 1'b0;
      O_PANEL_PINS_OE          <= 1'b0;
    end
    else
    begin
      O_PANEL_CLOCK_OUT <= pnl_live_w & ~s2_q.pclk;
      if (pop_w)
        even_tgl_q <= ~even_tgl_q;
      O_PANEL_EVEN_LATCH_CLOCK <= even_on_w & even_tgl_q;
      O_PANEL_PINS_OE          <= ~isa_w;
    end
  end

  assign O_PANEL_SUPPLY_ENABLE    = supply_w;
  assign O_PANEL_BACKLIGHT_ENABLE = backlight_w;

  // Monitor id channel straight from the panel config register
  assign O_MONITOR_ID_SERIAL_CLOCK   = cfg_pnl_q[PNL_ID_CLK_BIT];
  assign O_MONITOR_ID_SERIAL_LINE_O  = cfg_pnl_q[PNL_ID_LINE_BIT];
  assign O_MONITOR_ID_SERIAL_LINE_OE = cfg_pnl_q[PNL_ID_DIR_BIT];

  default clocking cb_sys @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  chk_fifo_fill: assert property (
    cap_vld_q && fifo_in_ready && !pop_w
    |=> fifo_level == $past(fifo_level) + 1'b1)
    else $error("captured pixel not stored");

  chk_inactive_blank: assert property (
    pop_w && !fifo_out.active
    |=> O_PANEL_DATA_BUS == '0 && O_VIDEO_DATA == '0)
    else $error("inactive pixel reached the outputs");

  chk_line_sync_tap: assert property (
    pop_w && line_dly_w == '0
    |=> O_CRT_LINE_SYNC == ($past(fifo_out.line) ^ $past(line_pol_w)))
    else $error("crt line sync misaligned");

  chk_frame_sync_tap: assert property (
    pop_w && frame_dly_w == '0
    |=> O_CRT_FRAME_SYNC == ($past(fifo_out.frame) ^ $past(frame_pol_w)))
    else $error("crt frame sync misaligned");

  chk_id_line_dir: assert property (
    wr_pnl_w
    |=> O_MONITOR_ID_SERIAL_LINE_OE == $past(I_REG_WDATA[PNL_ID_DIR_BIT]))
    else $error("id line direction not taken");

  chk_panel_data_off: assert property (
    !cfg_pnl_q[PNL_DATA_EN_BIT] |=> O_PANEL_DATA_BUS == '0)
    else $error("panel data not forced low");

  chk_even_clock_off: assert property (
    !cfg_pnl_q[PNL_EVEN_EN_BIT] |=> !O_PANEL_EVEN_LATCH_CLOCK)
    else $error("even latch clock runs while disabled");

  chk_isa_panel_off: assert property (
    isa_w |=> !O_PANEL_PINS_OE && !O_PANEL_CLOCK_OUT &&
              O_PANEL_DATA_BUS == '0 && !O_PANEL_SUPPLY_ENABLE)
    else $error("panel outputs live in isa master mode");

  chk_panel_aligned: assert property (
    pop_w && pnl_live_w
    |=> O_PANEL_ACTIVE_OUT == $past(fifo_out.active) &&
        O_PANEL_LINE_SYNC_OUT == $past(fifo_out.pline) &&
        O_PANEL_FRAME_SYNC_OUT == $past(fifo_out.pframe))
    else $error("panel syncs out of step with data");

endmodule : disp_out

// [test/pix_src.sv]
// Display controller model: 80 ns pixel clock, random pixels and syncs.
// Assumes i_en changes away from pixel clock edges.
module pix_src (
  // Control
  input  wire logic   i_en,
  // Pixel port: word = {overlay, pixel}, ctl = {active, line, frame, pline}
  output logic        o_pclk,
  output logic [31:0] o_word,
  output logic [3:0]  o_ctl
);
  timeunit 1ns;
  timeprecision 100ps;
  int          seed = 33432;
  logic        live = 1'b0;
  logic        was  = 1'b0;
  logic [31:0] r;
  initial
  begin
    o_pclk = 1'b0;
    o_word = '0;
    o_ctl  = '0;
    forever
    begin
      #40;
      o_pclk = 1'b0;
      live   = i_en;
      o_word = $random(seed);
      r      = $random(seed);
      // One idle word trails each stream, then the clock stops low
      o_ctl  = {4{live}} & r[3:0];
      #40;
      o_pclk = live | was;
      was    = live;
    end
  end
endmodule : pix_src

// [test/display_pixel_panel_output_tb.sv]
// Bench for the display output stage with a pixel source model.
// Assumes the power sequencer needs about 2000 cycles to reach backlight.
module display_pixel_panel_output_tb
  import disp_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst_b = 0, wr = 0, rd = 0, isa = 0, en = 0;
  logic        rd_seen = 0, pclk, cl, cf, pl, pf, pa, ioe, io, poe, sup, bkl;
  logic        pck, ev, msc;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, word, cv = 32'h1, cp = '0, cs = '0;
  logic [3:0]  ctl;
  logic [15:0] vid;
  logic [17:0] pd;
  logic [35:0] pq[$];
  logic [31:0] rq[$];
  int          n_mismatch = 0, n_tests = 0, cycles = 0, seed = 33432;
  int          n_pck = 0, n_ev = 0, n_pix = 0;
  always #5 clk = ~clk;
  pix_src u_src (.i_en(en), .o_pclk(pclk), .o_word(word), .o_ctl(ctl));
  disp_out u_dut (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_GRAPHICS_DOT_CLOCK(pclk), .I_PIXEL_DATA(word[23:0]),
    .I_VIDEO_OVERLAY_BUS(word[31:24]), .I_DISPLAY_ACTIVE_QUALIFIER(ctl[3]),
    .I_LINE_SYNC(ctl[2]), .I_FRAME_SYNC(ctl[1]),
    .I_PANEL_LINE_SYNC_IN(ctl[0]), .I_PANEL_FRAME_SYNC_IN(ctl[1]),
    .I_ISA_MASTER_MODE(isa), .O_CRT_LINE_SYNC(cl), .O_CRT_FRAME_SYNC(cf),
    .O_VIDEO_DATA(vid), .O_PANEL_DATA_BUS(pd), .O_PANEL_CLOCK_OUT(pck),
    .O_PANEL_EVEN_LATCH_CLOCK(ev), .O_PANEL_LINE_SYNC_OUT(pl),
    .O_PANEL_FRAME_SYNC_OUT(pf), .O_PANEL_ACTIVE_OUT(pa),
    .O_PANEL_PINS_OE(poe), .O_PANEL_SUPPLY_ENABLE(sup),
    .O_PANEL_BACKLIGHT_ENABLE(bkl), .O_MONITOR_ID_SERIAL_CLOCK(msc),
    .I_MONITOR_ID_SERIAL_LINE_I(ioe ? io : 1'b1),
    .O_MONITOR_ID_SERIAL_LINE_O(io), .O_MONITOR_ID_SERIAL_LINE_OE(ioe));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(logic [7:0] a, logic [31:0] e);
    rq.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  task automatic stream;
    en <= 1'b1;
    repeat (200) @(posedge clk);
    en <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : stream
  task automatic cmp_pixel(logic [35:0] w);
    logic [17:0] e;
    logic [15:0] v;
    e = cv[29] ? {w[15:11], w[15], w[10:5], w[4:0], w[4]}
               : {w[23:18], w[15:10], w[7:2]};
    e = (w[35] && cp[7]) ? e : 18'h0;
    check("panel data", 32'(pd), 32'(e));
    v = (cv[29] && w[35]) ? {w[23:16], w[31:24]} : 16'h0;
    check("video", 32'(vid), 32'(v));
    check("crt line", 32'(cl), 32'(w[34] ^ cs[8]));
    check("crt frame", 32'(cf), 32'(w[33] ^ cs[9]));
    check("panel line", 32'(pl), 32'(w[32]));
    check("panel frame", 32'(pf), 32'(w[33]));
    check("panel active", 32'(pa), 32'(w[35]));
  endtask : cmp_pixel
  always @(posedge pclk)
    pq.push_back({ctl, word});
  always @(posedge pclk)
    n_pix++;
  always @(posedge pck)
    n_pck++;
  always @(posedge ev)
    n_ev++;
  always @(posedge pclk)
  begin
    #1;
    if (pq.size() > 1)
    begin
      repeat (6) @(posedge clk);
      cmp_pixel(pq.pop_front());
    end
  end
  always @(posedge clk)
    rd_seen <= rd;
  always @(negedge clk)
    if (rd_seen)
      check("register", rdata, rq.pop_front());
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(REG_CFG_VIDEO, VID_RESET);
    rd_reg(8'h10, 32'h0);
    cs = $random(seed);
    wr_reg(REG_SYNC_CTRL, cs);
    rd_reg(REG_SYNC_CTRL, cs & SYN_MASK);
    cs = '0;
    wr_reg(REG_SYNC_CTRL, cs);
    cp = 32'h0100_10C0;
    wr_reg(REG_CFG_PANEL, cp);
    rd_reg(REG_CFG_PANEL, cp);
    check("id line oe", 32'(ioe), 32'h1);
    check("supply", 32'(sup), 32'h1);
    repeat (2100) @(posedge clk);
    check("backlight", 32'(bkl), 32'h1);
    stream();
    cv = 32'h2000_0001;
    cs = 32'h0000_0300;
    wr_reg(REG_CFG_VIDEO, cv);
    wr_reg(REG_SYNC_CTRL, cs);
    stream();
    cp = 32'h0700_1040;
    wr_reg(REG_CFG_PANEL, cp);
    rd_reg(REG_CFG_PANEL, cp);
    // Id line looped back high, panel fully up, one trailing word queued
    rd_reg(REG_STATUS, 32'h0000_0172);
    check("id clock", 32'(msc), 32'h1);
    stream();
    // One panel clock rise per pixel plus one as the data phase opens
    check("panel clock", n_pck, n_pix + 1);
    check("even clock", n_ev, n_pix / 2);
    isa <= 1'b1;
    repeat (6) @(posedge clk);
    check("panel pins oe", 32'(poe), 32'h0);
    check("supply isa", 32'(sup), 32'h0);
    results();
  end
endmodule : display_pixel_panel_output_tb
